// ### rtl/boot_resp_pkg.sv
/*
  Shared constants and types for the boot serial command responder:
  command codes, acknowledge codes, record layout and state encoding.
  Assumes the package is compiled before every design file that uses it.
*/
package boot_resp_pkg;

  localparam logic [7:0] CMD_SUM = 8'h20;
  localparam logic [7:0] CMD_INFO = 8'h30;
  localparam logic [7:0] CMD_ERASE = 8'h40;
  localparam logic [7:0] ERASE_CONFIRM = 8'h54;
  localparam logic [7:0] MODE_ACK = 8'h86;
  localparam logic [3:0] ACK_RX_ERR = 4'h8;
  localparam logic [3:0] ACK_CMD_ERR = 4'h1;
  localparam logic [7:0] LAST_CMD_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;

  // fixed addresses of the information record, sent least significant byte first
  localparam logic [31:0] PW_START_ADDR = 32'h00027ef4;
  localparam logic [31:0] RAM_START_ADDR = 32'h00001000;
  localparam logic [31:0] USER_RAM_END_ADDR = 32'h00001dff;
  localparam logic [31:0] RAM_END_ADDR = 32'h00001fff;
  localparam logic [31:0] FLASH_START_ADDR = 32'h00010000;
  localparam logic [31:0] FLASH_END_ADDR = 32'h00027fff;
  localparam logic [15:0] SECTOR_COUNT = 16'h000c;
  localparam logic [23:0] SECTOR_START = 24'h010000;
  localparam logic [23:0] SECTOR_WORDS = 24'h001000;
  localparam logic [23:0] SECTOR_REPEAT = 24'h00000c;

  // status word bit positions
  localparam int STAT_READ_OPEN = 0;
  localparam int STAT_WRITE_OPEN = 1;
  localparam int STAT_UNDIVIDED = 2;

  // record indexes; index 0 is the fifth byte of the exchange
  localparam logic [5:0] IDX_SWID = 6'h00;
  localparam logic [5:0] IDX_PART = 6'h04;
  localparam logic [5:0] IDX_PW = 6'h10;
  localparam logic [5:0] IDX_RAMS = 6'h14;
  localparam logic [5:0] IDX_URAME = 6'h18;
  localparam logic [5:0] IDX_RAME = 6'h1c;
  localparam logic [5:0] IDX_DUMMY = 6'h20;
  localparam logic [5:0] IDX_STAT = 6'h28;
  localparam logic [5:0] IDX_FLS = 6'h2a;
  localparam logic [5:0] IDX_FLE = 6'h2e;
  localparam logic [5:0] IDX_SECN = 6'h32;
  localparam logic [5:0] IDX_SECT = 6'h34;
  localparam logic [5:0] IDX_LAST = 6'h3c;
  localparam int PART_CHARS = 12;

  typedef enum logic [3:0] {
    S_MODE = 4'b0000,
    S_MODE_ACK = 4'b0001,
    S_CMD = 4'b0010,
    S_ACK = 4'b0011,
    S_SUM_WAIT = 4'b0100,
    S_SUM_HI = 4'b0101,
    S_SUM_LO = 4'b0110,
    S_SUM_CK = 4'b0111,
    S_INFO = 4'b1000,
    S_INFO_CK = 4'b1001,
    S_ERASE_CONF = 4'b1010,
    S_ERASE_RUN = 4'b1011,
    S_HALT = 4'b1100
  } state_t;

endpackage

// ### rtl/two_entry_buffer.sv
/*
  Two-entry first-in first-out buffer with valid and ready on both sides.
  Assumes both sides run on clock_in; data out is read from stored flops.
*/
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int WIDTH = 8
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  logic [WIDTH-1:0] store [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic do_write;
  logic do_read;

  assign in_ready_out = (count != 2'd2);
  assign out_valid_out = (count != 2'd0);
  assign out_data_out = store[rd_ptr];
  assign do_write = in_valid_in && in_ready_out;
  assign do_read = out_valid_out && out_ready_in;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      store[0] <= '0;
      store[1] <= '0;
    end else if (do_write) begin
      store[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      if (do_write) begin
        wr_ptr <= ~wr_ptr;
      end
      if (do_read) begin
        rd_ptr <= ~rd_ptr;
      end
      if (do_write && !do_read) begin
        count <= count + 2'd1;
      end else if (do_read && !do_write) begin
        count <= count - 2'd1;
      end
    end
  end

endmodule

// ### rtl/boot_serial_command_responder.sv
/*
  Boot-mode command responder: takes bytes from a serial receiver, answers
  the mode setting byte, then the checksum, information and erase commands.
  Assumes a byte receiver on clock_in that flags framing, parity and overrun,
  a flash summing engine and an erase engine with start and done handshakes.
*/
// Notes on behaviour
// - checksum code 20H echoed, routine then entered
// - receive error answers upper nibble plus 8
// - undefined command answers upper nibble plus 1
// - error upper nibble from previous command byte
// - defined command echoed, then its sequence runs
// - sum sent high byte, then low byte
// - seventh byte negates sum of both bytes
// - information code 30H echoed, record then streamed
// - record bytes five-eight are software id
// - twelve-character part name, space padded
// - password start address, low byte first
// - ram start and end addresses, low first
// - bytes thirty-seven to forty-four are filler
// - status word: read, write, undivided flags
// - flash start and end addresses, low first
// - sector count twelve, low byte first
// - sector layout: start, word size, repeat
// - byte sixty-six negates record byte sum
// - erase code 40H echoed, confirmation follows
// - confirmation byte: error, echo-and-erase, or reject
// - mode byte answered 86H, else halt silently
`timescale 1ns/1ps
module boot_serial_command_responder #(
  parameter logic [95:0] PART_NAME = 96'h4445_5649_4345_3031_2020_2020 // arbitrary value
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_framing_err_in,
  input wire logic rx_parity_err_in,
  input wire logic rx_overrun_err_in,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output logic [7:0] tx_data_out,
  input wire logic link_ready_in,
  input wire logic baud_ok_in,
  output logic sum_start_out,
  input wire logic sum_done_in,
  input wire logic [15:0] flash_sum_in,
  input wire logic [31:0] software_id_in,
  input wire logic read_unprotected_in,
  input wire logic write_unprotected_in,
  input wire logic flash_undivided_in,
  output logic erase_start_out,
  input wire logic erase_done_in,
  output logic halted_out,
  output logic idle_out
);

  boot_resp_pkg::state_t state;
  boot_resp_pkg::state_t after_ack;
  logic [7:0] ack_byte;
  logic [7:0] last_cmd;
  logic [15:0] sum_value;
  logic [5:0] info_idx;
  logic [7:0] record_sum;
  logic [7:0] push_data;
  logic push_valid;
  logic push_ready;
  logic push_fire;
  logic rx_error;
  logic [15:0] status_word;

  // byte k of a 32-bit little-endian field
  function automatic logic [7:0] byte_of32(input logic [31:0] v, input logic [5:0] k);
    byte_of32 = v[{k[1:0], 3'b000} +: 8];
  endfunction

  // negated modulo-256 sum, the trailing check byte of the sum and information replies
  function automatic logic [7:0] neg_sum(input logic [7:0] s);
    neg_sum = boot_resp_pkg::ZERO_BYTE - s;
  endfunction

  // one record byte for index idx (index 0 is exchange byte five)
  function automatic logic [7:0] info_byte(
    input logic [5:0] idx,
    input logic [31:0] swid,
    input logic [95:0] part,
    input logic [15:0] stat
  );
    logic [5:0] k;
    logic [5:0] sec;
    logic [71:0] layout;
    k = '0;
    sec = '0;
    layout = {boot_resp_pkg::SECTOR_REPEAT, boot_resp_pkg::SECTOR_WORDS,
              boot_resp_pkg::SECTOR_START};
    info_byte = boot_resp_pkg::DUMMY_BYTE;
    if (idx < boot_resp_pkg::IDX_PART) begin
      info_byte = byte_of32(swid, idx - boot_resp_pkg::IDX_SWID);
    end else if (idx < boot_resp_pkg::IDX_PW) begin
      k = idx - boot_resp_pkg::IDX_PART;
      info_byte = part[(7'(boot_resp_pkg::PART_CHARS - 1) - 7'(k)) * 7'd8 +: 8];
    end else if (idx < boot_resp_pkg::IDX_RAMS) begin
      info_byte = byte_of32(boot_resp_pkg::PW_START_ADDR, idx - boot_resp_pkg::IDX_PW);
    end else if (idx < boot_resp_pkg::IDX_URAME) begin
      info_byte = byte_of32(boot_resp_pkg::RAM_START_ADDR, idx - boot_resp_pkg::IDX_RAMS);
    end else if (idx < boot_resp_pkg::IDX_RAME) begin
      info_byte = byte_of32(boot_resp_pkg::USER_RAM_END_ADDR,
                            idx - boot_resp_pkg::IDX_URAME);
    end else if (idx < boot_resp_pkg::IDX_DUMMY) begin
      info_byte = byte_of32(boot_resp_pkg::RAM_END_ADDR, idx - boot_resp_pkg::IDX_RAME);
    end else if (idx < boot_resp_pkg::IDX_STAT) begin
      info_byte = boot_resp_pkg::DUMMY_BYTE;
    end else if (idx < boot_resp_pkg::IDX_FLS) begin
      info_byte = (idx == boot_resp_pkg::IDX_STAT) ? stat[7:0] : stat[15:8];
    end else if (idx < boot_resp_pkg::IDX_FLE) begin
      info_byte = byte_of32(boot_resp_pkg::FLASH_START_ADDR, idx - boot_resp_pkg::IDX_FLS);
    end else if (idx < boot_resp_pkg::IDX_SECN) begin
      info_byte = byte_of32(boot_resp_pkg::FLASH_END_ADDR, idx - boot_resp_pkg::IDX_FLE);
    end else if (idx < boot_resp_pkg::IDX_SECT) begin
      info_byte = (idx == boot_resp_pkg::IDX_SECN) ?
                  boot_resp_pkg::SECTOR_COUNT[7:0] : boot_resp_pkg::SECTOR_COUNT[15:8];
    end else begin
      sec = idx - boot_resp_pkg::IDX_SECT;
      info_byte = layout[{sec[3:0], 3'b000} +: 8];
    end
  endfunction

  // any receiver fault on a command or confirmation byte selects the receive-error answer
  assign rx_error = rx_framing_err_in || rx_parity_err_in || rx_overrun_err_in;

  always_comb begin
    status_word = '0;
    status_word[boot_resp_pkg::STAT_READ_OPEN] = read_unprotected_in;
    status_word[boot_resp_pkg::STAT_WRITE_OPEN] = write_unprotected_in;
    status_word[boot_resp_pkg::STAT_UNDIVIDED] = flash_undivided_in;
  end

  // byte offered to the transmit buffer in each sending state
  always_comb begin
    push_valid = 1'b0;
    push_data = boot_resp_pkg::ZERO_BYTE;
    unique case (state)
      boot_resp_pkg::S_MODE_ACK: begin
        push_valid = 1'b1;
        push_data = boot_resp_pkg::MODE_ACK;
      end
      boot_resp_pkg::S_ACK: begin
        push_valid = 1'b1;
        push_data = ack_byte;
      end
      boot_resp_pkg::S_SUM_HI: begin
        push_valid = 1'b1;
        push_data = sum_value[15:8];
      end
      boot_resp_pkg::S_SUM_LO: begin
        push_valid = 1'b1;
        push_data = sum_value[7:0];
      end
      boot_resp_pkg::S_SUM_CK: begin
        push_valid = 1'b1;
        push_data = neg_sum(sum_value[15:8] + sum_value[7:0]);
      end
      boot_resp_pkg::S_INFO: begin
        push_valid = 1'b1;
        push_data = info_byte(info_idx, software_id_in, PART_NAME, status_word);
      end
      boot_resp_pkg::S_INFO_CK: begin
        push_valid = 1'b1;
        push_data = neg_sum(record_sum);
      end
      boot_resp_pkg::S_MODE, boot_resp_pkg::S_CMD, boot_resp_pkg::S_SUM_WAIT,
      boot_resp_pkg::S_ERASE_CONF, boot_resp_pkg::S_ERASE_RUN, boot_resp_pkg::S_HALT: begin
        push_valid = 1'b0;
      end
    endcase
  end

  assign push_fire = push_valid && push_ready;

  // main sequencer
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= boot_resp_pkg::S_MODE;
      after_ack <= boot_resp_pkg::S_CMD;
      ack_byte <= boot_resp_pkg::ZERO_BYTE;
    end else begin
      unique case (state)
        boot_resp_pkg::S_MODE: begin
          if (rx_valid_in && link_ready_in) begin
            state <= baud_ok_in ? boot_resp_pkg::S_MODE_ACK : boot_resp_pkg::S_HALT;
          end
        end
        boot_resp_pkg::S_MODE_ACK: begin
          if (push_fire) begin
            state <= boot_resp_pkg::S_CMD;
          end
        end
        boot_resp_pkg::S_CMD: begin
          if (rx_valid_in) begin
            state <= boot_resp_pkg::S_ACK;
            after_ack <= boot_resp_pkg::S_CMD;
            if (rx_error) begin
              ack_byte <= {last_cmd[7:4], boot_resp_pkg::ACK_RX_ERR};
            end else if (rx_data_in == boot_resp_pkg::CMD_SUM) begin
              ack_byte <= rx_data_in;
              after_ack <= boot_resp_pkg::S_SUM_WAIT;
            end else if (rx_data_in == boot_resp_pkg::CMD_INFO) begin
              ack_byte <= rx_data_in;
              after_ack <= boot_resp_pkg::S_INFO;
            end else if (rx_data_in == boot_resp_pkg::CMD_ERASE) begin
              ack_byte <= rx_data_in;
              after_ack <= boot_resp_pkg::S_ERASE_CONF;
            end else begin
              ack_byte <= {last_cmd[7:4], boot_resp_pkg::ACK_CMD_ERR};
            end
          end
        end
        boot_resp_pkg::S_ACK: begin
          if (push_fire) begin
            state <= after_ack;
          end
        end
        boot_resp_pkg::S_SUM_WAIT: begin
          if (sum_done_in) begin
            state <= boot_resp_pkg::S_SUM_HI;
          end
        end
        boot_resp_pkg::S_SUM_HI: begin
          if (push_fire) begin
            state <= boot_resp_pkg::S_SUM_LO;
          end
        end
        boot_resp_pkg::S_SUM_LO: begin
          if (push_fire) begin
            state <= boot_resp_pkg::S_SUM_CK;
          end
        end
        boot_resp_pkg::S_SUM_CK: begin
          if (push_fire) begin
            state <= boot_resp_pkg::S_CMD;
          end
        end
        boot_resp_pkg::S_INFO: begin
          if (push_fire && info_idx == boot_resp_pkg::IDX_LAST) begin
            state <= boot_resp_pkg::S_INFO_CK;
          end
        end
        boot_resp_pkg::S_INFO_CK: begin
          if (push_fire) begin
            state <= boot_resp_pkg::S_CMD;
          end
        end
        boot_resp_pkg::S_ERASE_CONF: begin
          if (rx_valid_in) begin
            state <= boot_resp_pkg::S_ACK;
            after_ack <= boot_resp_pkg::S_CMD;
            if (rx_error) begin
              ack_byte <= {last_cmd[7:4], boot_resp_pkg::ACK_RX_ERR};
            end else if (rx_data_in == boot_resp_pkg::ERASE_CONFIRM) begin
              ack_byte <= rx_data_in;
              after_ack <= boot_resp_pkg::S_ERASE_RUN;
            end else begin
              ack_byte <= {last_cmd[7:4], boot_resp_pkg::ACK_CMD_ERR};
            end
          end
        end
        boot_resp_pkg::S_ERASE_RUN: begin
          if (erase_done_in) begin
            state <= boot_resp_pkg::S_CMD;
          end
        end
        boot_resp_pkg::S_HALT: begin
          state <= boot_resp_pkg::S_HALT;
        end
        default: begin
          state <= boot_resp_pkg::S_HALT;
        end
      endcase
    end
  end

  // upper nibble source for error answers; taken after the answer is formed
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      last_cmd <= boot_resp_pkg::LAST_CMD_RESET;
    end else if (state == boot_resp_pkg::S_CMD && rx_valid_in && !rx_error) begin
      last_cmd <= rx_data_in;
    end
  end

  // start pulses for the summing and erase engines, one cycle each
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sum_start_out <= 1'b0;
      erase_start_out <= 1'b0;
    end else begin
      sum_start_out <= push_fire && state == boot_resp_pkg::S_ACK &&
                       after_ack == boot_resp_pkg::S_SUM_WAIT;
      erase_start_out <= push_fire && state == boot_resp_pkg::S_ACK &&
                         after_ack == boot_resp_pkg::S_ERASE_RUN;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sum_value <= '0;
    end else if (state == boot_resp_pkg::S_SUM_WAIT && sum_done_in) begin
      sum_value <= flash_sum_in;
    end
  end

  // record index and running sum over bytes five to sixty-five
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      info_idx <= '0;
      record_sum <= boot_resp_pkg::ZERO_BYTE;
    end else if (state == boot_resp_pkg::S_ACK) begin
      info_idx <= '0;
      record_sum <= boot_resp_pkg::ZERO_BYTE;
    end else if (state == boot_resp_pkg::S_INFO && push_fire) begin
      info_idx <= info_idx + 6'd1;
      record_sum <= record_sum + push_data;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      halted_out <= 1'b0;
      idle_out <= 1'b0;
    end else begin
      halted_out <= (state == boot_resp_pkg::S_HALT);
      idle_out <= (state == boot_resp_pkg::S_CMD);
    end
  end

  two_entry_buffer #(
    .WIDTH(8)
  ) tx_buffer (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .in_data_in(push_data),
    .out_valid_out(tx_valid_out),
    .out_ready_in(tx_ready_in),
    .out_data_out(tx_data_out)
  );

endmodule

// ### verif/boot_resp_properties.sv
/* Port checker for the boot command responder: answer codes, stalls, starts.
   Assumes command bytes are spaced and each reply is taken before the next. */
`timescale 1ns/1ps
module boot_resp_properties (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_framing_err_in,
  input wire logic rx_parity_err_in,
  input wire logic rx_overrun_err_in,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic [7:0] tx_data_out,
  input wire logic sum_start_out,
  input wire logic erase_start_out,
  input wire logic halted_out,
  input wire logic idle_out
);
  logic rx_err, prev_rx, take, known, rx_bad;
  logic [3:0] cmd_hi;
  logic [7:0] rx_last, want;
  assign rx_err = rx_framing_err_in | rx_parity_err_in | rx_overrun_err_in;
  assign known = rx_data_in == 8'h20 || rx_data_in == 8'h30 || rx_data_in == 8'h40;
  assign take = rx_valid_in && idle_out && !prev_rx;
  // expected answer and upper nibble of the last clean command
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_rx <= 1'b0;
      rx_last <= 8'h00;
      rx_bad <= 1'b0;
      cmd_hi <= 4'h0;
      want <= 8'h00;
    end else begin
      prev_rx <= rx_valid_in;
      if (rx_valid_in) begin
        rx_last <= rx_data_in;
        rx_bad <= rx_err;
      end
      if (take) begin
        want <= rx_err ? {cmd_hi, 4'h8} : known ? rx_data_in : {cmd_hi, 4'h1};
        if (!rx_err) begin
          cmd_hi <= rx_data_in[7:4];
        end
      end
    end
  end
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);
  property p_rx_err;
    take && rx_err && !tx_valid_out |-> ##[1:4] (tx_valid_out && tx_data_out == want);
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("receive error answer wrong");
  property p_err_hi;
    take && rx_err && !tx_valid_out |-> ##[1:4] (tx_valid_out && tx_data_out[7:4] == cmd_hi);
  endproperty
  a_err_hi: assert property (p_err_hi) else $error("error answer nibble wrong");
  property p_undef;
    take && !rx_err && !known && !tx_valid_out |-> ##[1:4] (tx_valid_out && tx_data_out == want);
  endproperty
  a_undef: assert property (p_undef) else $error("undefined command answer wrong");
  property p_echo;
    take && !rx_err && known && !tx_valid_out |-> ##[1:4] (tx_valid_out && tx_data_out == want);
  endproperty
  a_echo: assert property (p_echo) else $error("command echo wrong");
  property p_hold;
    tx_valid_out && !tx_ready_in |=> (tx_valid_out && $stable(tx_data_out));
  endproperty
  a_hold: assert property (p_hold) else $error("stalled reply byte lost");
  property p_sum_cause;
    $rose(sum_start_out) |-> (rx_last == 8'h20 && !rx_bad);
  endproperty
  a_sum_cause: assert property (p_sum_cause) else $error("sum started without command");
  property p_erase_cause;
    $rose(erase_start_out) |-> (rx_last == 8'h54 && !rx_bad);
  endproperty
  a_erase_cause: assert property (p_erase_cause) else $error("erase without confirm");
  property p_halt;
    halted_out |=> (halted_out && !tx_valid_out);
  endproperty
  a_halt: assert property (p_halt) else $error("halted device sent data");
  c_take: cover property (take && known);
  c_sum: cover property (sum_start_out);
  c_erase: cover property (erase_start_out);
  c_halt: cover property (halted_out);
endmodule

bind boot_serial_command_responder boot_resp_properties chk (.clock_in, .resetn_in,
  .rx_valid_in, .rx_data_in, .rx_framing_err_in, .rx_parity_err_in, .rx_overrun_err_in,
  .tx_valid_out, .tx_ready_in, .tx_data_out, .sum_start_out, .erase_start_out,
  .halted_out, .idle_out);

// ### verif/ctrl_model.sv
/* Programming controller model: sends bytes with receive-error flags and
   collects replies, stalling every other cycle while slow_in is high. */
`timescale 1ns/1ps
module ctrl_model (
  input wire logic clock_in,
  input wire logic slow_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic [2:0] rx_err_out,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out
);
  logic [7:0] got[$];
  logic phase = 1'b0;
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    rx_err_out = 3'h0;
    tx_ready_out = 1'b1;
  end
  always @(negedge clock_in) begin
    phase <= ~phase;
    tx_ready_out <= !slow_in || phase;
  end
  always @(posedge clock_in) begin
    if (tx_valid_in && tx_ready_out) begin
      got.push_back(tx_data_in);
    end
  end
  // one-cycle byte; flags are framing, parity, overrun
  task automatic send(input logic [7:0] b, input logic [2:0] e);
    @(negedge clock_in);
    rx_valid_out = 1'b1;
    rx_data_out = b;
    rx_err_out = e;
    @(negedge clock_in);
    rx_valid_out = 1'b0;
    rx_data_out = ~b;
    rx_err_out = 3'h0;
  endtask
endmodule

// ### verif/tb_top.sv
/* Self-checking bench for the boot command responder.
   Assumes the controller model on the serial side; engines driven here. */
`timescale 1ns/1ps
module tb_top;
  localparam logic [95:0] NAME = 96'h5041_5254_5f4e_414d_4530_3120; // arbitrary
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic slow = 1'b0;
  logic link_ready_in = 1'b1;
  logic baud_ok_in = 1'b1;
  logic sum_done_in = 1'b0;
  logic erase_done_in = 1'b0;
  logic [15:0] flash_sum_in = 16'ha5c3;
  logic [31:0] software_id_in = 32'h4433_2211;
  logic [7:0] want[$];
  logic rx_valid_in, tx_valid_out, tx_ready_in, sum_start_out, erase_start_out;
  logic halted_out, idle_out;
  logic [7:0] rx_data_in, tx_data_out;
  logic [2:0] rx_err;
  int num_errors = 0;
  int num_checks = 0;
  always #5 clock_in = ~clock_in;
  ctrl_model host (.clock_in, .slow_in(slow), .rx_valid_out(rx_valid_in),
    .rx_data_out(rx_data_in), .rx_err_out(rx_err), .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in));
  boot_serial_command_responder #(.PART_NAME(NAME)) DUT (.clock_in, .resetn_in,
    .rx_valid_in, .rx_data_in, .rx_framing_err_in(rx_err[0]),
    .rx_parity_err_in(rx_err[1]), .rx_overrun_err_in(rx_err[2]), .tx_valid_out,
    .tx_ready_in, .tx_data_out, .link_ready_in, .baud_ok_in, .sum_start_out,
    .sum_done_in, .flash_sum_in, .software_id_in, .read_unprotected_in(1'b1),
    .write_unprotected_in(1'b0), .flash_undivided_in(1'b1), .erase_start_out,
    .erase_done_in, .halted_out, .idle_out);
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic timeout(input string what);
    $display("Error %s expected event seen none", what);
    num_errors++;
    conclude();
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rst;
    @(negedge clock_in);
    resetn_in = 1'b0;
    repeat (5) @(negedge clock_in);
    resetn_in = 1'b1;
  endtask
  task automatic get(output logic [7:0] b);
    int n;
    n = 0;
    while (host.got.size() == 0 && n < 3000) begin
      @(negedge clock_in);
      n++;
    end
    if (n == 3000) begin
      timeout("reply byte");
    end
    b = host.got.pop_front();
  endtask
  task automatic expect_b(input string what, input logic [7:0] exp);
    logic [7:0] b;
    get(b);
    check(what, b, exp);
  endtask
  task automatic wait_for(input logic e, input string what);
    int n;
    n = 0;
    while ((e ? erase_start_out : sum_start_out) !== 1'b1 && n < 200) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    if (n == 200) begin
      timeout(what);
    end
  endtask
  task automatic add(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      want.push_back(v[8*i +: 8]);
    end
  endtask
  task automatic t_mode;
    baud_ok_in = 1'b0;
    host.send(8'h86, 3'h0);
    repeat (8) @(negedge clock_in);
    check("halted", 8'(halted_out), 8'h01);
    check("halt silent", 8'(host.got.size()), 8'h00);
    rst();
    link_ready_in = 1'b0;
    baud_ok_in = 1'b1;
    host.send(8'h86, 3'h0);
    repeat (8) @(negedge clock_in);
    check("link not ready", 8'(host.got.size()), 8'h00);
    link_ready_in = 1'b1;
    host.send(8'h86, 3'h0);
    expect_b("mode ack", 8'h86);
  endtask
  task automatic t_sum;
    slow = 1'b1;
    host.send(8'h20, 3'h0);
    wait_for(1'b0, "sum start");
    @(negedge clock_in);
    sum_done_in = 1'b1;
    @(negedge clock_in);
    sum_done_in = 1'b0;
    expect_b("sum echo", 8'h20);
    expect_b("sum high", 8'ha5);
    expect_b("sum low", 8'hc3);
    expect_b("sum check", 8'h00 - 8'ha5 - 8'hc3);
    slow = 1'b0;
  endtask
  task automatic t_err;
    for (int i = 0; i < 3; i++) begin
      host.send(8'h20, 3'h1 << i);
      expect_b("receive error ack", 8'h28);
    end
    host.send(8'h10, 3'h0);
    expect_b("undefined ack", 8'h21);
    host.send(8'h60, 3'h0);
    expect_b("undefined ack again", 8'h11);
    host.send(8'h60, 3'h4);
    expect_b("error after undefined", 8'h68);
    check("idle after error", 8'(idle_out), 8'h01);
  endtask
  task automatic t_info;
    logic [7:0] b;
    logic [7:0] sum;
    sum = 8'h00;
    slow = 1'b1;
    add(software_id_in, 4);
    for (int i = 0; i < 12; i++) begin
      want.push_back(NAME[95-8*i -: 8]);
    end
    add(32'h0002_7ef4, 4);
    add(32'h0000_1000, 4);
    add(32'h0000_1dff, 4);
    add(32'h0000_1fff, 4);
    add(32'h0000_0000, 4);
    add(32'h0000_0000, 4);
    add(32'h0000_0005, 2);
    add(32'h0001_0000, 4);
    add(32'h0002_7fff, 4);
    add(32'h0000_000c, 2);
    add(32'h0001_0000, 3);
    add(32'h0000_1000, 3);
    add(32'h0000_000c, 3);
    host.send(8'h30, 3'h0);
    expect_b("info echo", 8'h30);
    for (int i = 0; i < 61; i++) begin
      get(b);
      sum = sum + b;
      if (i < 32 || i > 39) begin
        check("record byte", b, want[i]);
      end
    end
    expect_b("info checksum", 8'h00 - sum);
    slow = 1'b0;
  endtask
  task automatic t_erase;
    host.send(8'h40, 3'h0);
    expect_b("erase echo", 8'h40);
    host.send(8'h54, 3'h1);
    expect_b("confirm receive error", 8'h48);
    host.send(8'h40, 3'h0);
    expect_b("erase echo again", 8'h40);
    host.send(8'h55, 3'h0);
    expect_b("wrong confirm", 8'h41);
    host.send(8'h40, 3'h0);
    expect_b("erase echo third", 8'h40);
    host.send(8'h54, 3'h0);
    wait_for(1'b1, "erase start");
    expect_b("confirm echo", 8'h54);
    @(negedge clock_in);
    erase_done_in = 1'b1;
    @(negedge clock_in);
    erase_done_in = 1'b0;
    host.send(8'h70, 3'h0);
    expect_b("back to command wait", 8'h41);
  endtask
  initial begin
    rst();
    t_mode();
    t_sum();
    t_err();
    t_info();
    t_erase();
    conclude();
  end
endmodule
